// *** fpd_pwm_top.v ***
// fine pulse modulator top: shared counter, banked byte registers, two output pins
`timescale 1ns/1ps
`default_nettype none
`include "fpd_defs.vh"
module fpd_pwm_top #(
	parameter CNT_W = 14
) (
	input wire sys_clk,
	input wire srst,
	input wire cpu_sel,
	input wire cpu_rd,
	input wire cpu_wr,
	input wire [1:0] cpu_addr,
	input wire [7:0] cpu_wdata,
	input wire shared_space_select_bit,
	input wire [1:0] res_ext_sel,
	output reg [7:0] cpu_rdata,
	output reg channel_a_output_pin,
	output reg channel_b_output_pin
);
	// resolution period length minus one for a 3-bit selection
	function [13:0] div_of;
		input [2:0] idx;
		begin
			case (idx)
				3'd0: div_of = `FPD_DIV_1;
				3'd1: div_of = `FPD_DIV_2;
				3'd2: div_of = `FPD_DIV_64;
				3'd3: div_of = `FPD_DIV_128;
				3'd4: div_of = `FPD_DIV_256;
				3'd5: div_of = `FPD_DIV_1024;
				3'd6: div_of = `FPD_DIV_4096;
				default: div_of = `FPD_DIV_16384;
			endcase
		end
	endfunction

	// counter bits 8..13 shown reversed in cpu bits 7..2
	function [5:0] rev6;
		input [5:0] v;
		integer k;
		begin
			for (k = 0; k < 6; k = k + 1) begin
				rev6[k] = v[5-k];
			end
		end
	endfunction

	// cpu view of the counter low byte
	function [7:0] cnt_low;
		input [13:0] c;
		input bank;
		begin
			cnt_low = {rev6(c[13:8]), 1'b1, bank};
		end
	endfunction

	reg [7:0] ctl_reg;
	reg [13:0] duty_a_reg;
	reg [13:0] duty_b_reg;
	reg carrier_a_reg;
	reg carrier_b_reg;
	reg bank_reg;
	reg [13:0] cnt_reg;
	reg [13:0] pre_reg;
	reg [7:0] temp_reg;

	reg [7:0] ctl_next;
	reg [13:0] duty_a_next;
	reg [13:0] duty_b_next;
	reg carrier_a_next;
	reg carrier_b_next;
	reg bank_next;
	reg [13:0] cnt_next;
	reg [13:0] pre_next;
	reg [7:0] temp_next;
	reg [7:0] rdata_next;

	wire acc;
	wire wr;
	wire rd;
	wire tick;
	wire [13:0] div_max;
	wire [13:0] cnt_wr_val;
	wire wave_a;
	wire wave_b;

	// registers only answer while the shared space is handed to this unit
	assign acc = cpu_sel & shared_space_select_bit;
	assign wr = acc & cpu_wr;
	assign rd = acc & cpu_rd & ~cpu_wr;

	// resolution index: counter clock select bit plus outside selection
	assign div_max = div_of({res_ext_sel, ctl_reg[`FPD_CTL_CLKSEL]});
	assign tick = (pre_reg == div_max);

	// counter word assembled from staged high byte and written low byte
	assign cnt_wr_val = {rev6(cpu_wdata[7:2]), temp_reg};

	always @* begin
		ctl_next = ctl_reg;
		duty_a_next = duty_a_reg;
		duty_b_next = duty_b_reg;
		carrier_a_next = carrier_a_reg;
		carrier_b_next = carrier_b_reg;
		bank_next = bank_reg;
		temp_next = temp_reg;
		rdata_next = cpu_rdata;
		cnt_next = cnt_reg;
		pre_next = pre_reg;

		// time base
		if (ctl_reg[`FPD_CTL_RUN]) begin
			cnt_next = `FPD_CNT_HOLD;
			pre_next = 14'h0000;
		end else if (tick) begin
			cnt_next = cnt_reg + 14'h0001;
			pre_next = 14'h0000;
		end else begin
			pre_next = pre_reg + 14'h0001;
		end

		if (wr) begin
			case (cpu_addr)
				`FPD_ADDR_PAIR0_HI: begin
					if (bank_reg) begin
						ctl_next = cpu_wdata;
					end else begin
						temp_next = cpu_wdata;
					end
				end
				`FPD_ADDR_PAIR0_LO: begin
					if (!bank_reg) begin
						duty_a_next = {temp_reg, cpu_wdata[7:2]};
						carrier_a_next = cpu_wdata[`FPD_DUTY_CARRIER];
					end
				end
				`FPD_ADDR_PAIR1_HI: begin
					temp_next = cpu_wdata;
				end
				`FPD_ADDR_PAIR1_LO: begin
					bank_next = cpu_wdata[`FPD_CNTL_BANK];
					if (bank_reg) begin
						cnt_next = cnt_wr_val;
						pre_next = 14'h0000;
					end else begin
						duty_b_next = {temp_reg, cpu_wdata[7:2]};
						carrier_b_next = cpu_wdata[`FPD_DUTY_CARRIER];
					end
				end
				default: begin
					temp_next = temp_reg;
				end
			endcase
		end

		if (rd) begin
			case (cpu_addr)
				`FPD_ADDR_PAIR0_HI: begin
					if (bank_reg) begin
						rdata_next = ctl_reg | `FPD_CTL_RO_ONES;
					end else begin
						rdata_next = duty_a_reg[13:6];
						temp_next = {duty_a_reg[5:0], carrier_a_reg, 1'b1};
					end
				end
				`FPD_ADDR_PAIR0_LO: begin
					if (bank_reg) begin
						rdata_next = `FPD_UNMAPPED;
					end else begin
						rdata_next = temp_reg;
					end
				end
				`FPD_ADDR_PAIR1_HI: begin
					if (bank_reg) begin
						rdata_next = cnt_reg[7:0];
						temp_next = cnt_low(cnt_reg, bank_reg);
					end else begin
						rdata_next = duty_b_reg[13:6];
						temp_next = {duty_b_reg[5:0], carrier_b_reg, bank_reg};
					end
				end
				`FPD_ADDR_PAIR1_LO: begin
					rdata_next = temp_reg;
				end
				default: begin
					rdata_next = cpu_rdata;
				end
			endcase
		end
	end

	always @(posedge sys_clk) begin
		if (srst) begin
			ctl_reg <= `FPD_CTL_RST;
			duty_a_reg <= `FPD_DUTY_RST;
			duty_b_reg <= `FPD_DUTY_RST;
			carrier_a_reg <= `FPD_CARRIER_RST;
			carrier_b_reg <= `FPD_CARRIER_RST;
			bank_reg <= `FPD_BANK_RST;
			cnt_reg <= `FPD_CNT_RST;
			pre_reg <= 14'h0000;
			temp_reg <= `FPD_TEMP_RST;
			cpu_rdata <= 8'h00;
		end else begin
			ctl_reg <= ctl_next & ~`FPD_CTL_RO_ONES;
			duty_a_reg <= duty_a_next;
			duty_b_reg <= duty_b_next;
			carrier_a_reg <= carrier_a_next;
			carrier_b_reg <= carrier_b_next;
			bank_reg <= bank_next;
			cnt_reg <= cnt_next;
			pre_reg <= pre_next;
			temp_reg <= temp_next;
			cpu_rdata <= rdata_next;
		end
	end

	// both channels share the one counter
	fpd_chan #(
		.CNT_W(CNT_W)
	) u_chan_a (
		.sys_clk(sys_clk),
		.srst(srst),
		.cnt(cnt_reg),
		.duty(duty_a_reg),
		.carrier_sel(carrier_a_reg),
		.wave_reg(wave_a)
	);

	fpd_chan #(
		.CNT_W(CNT_W)
	) u_chan_b (
		.sys_clk(sys_clk),
		.srst(srst),
		.cnt(cnt_reg),
		.duty(duty_b_reg),
		.carrier_sel(carrier_b_reg),
		.wave_reg(wave_b)
	);

	// pins: enable gates, polarity inverts, disabled pin stays low
	always @(posedge sys_clk) begin
		if (srst) begin
			channel_a_output_pin <= 1'b0;
			channel_b_output_pin <= 1'b0;
		end else begin
			channel_a_output_pin <= ctl_reg[`FPD_CTL_EN_A] &
				(wave_a ^ ctl_reg[`FPD_CTL_POL]);
			channel_b_output_pin <= ctl_reg[`FPD_CTL_EN_B] &
				(wave_b ^ ctl_reg[`FPD_CTL_POL]);
		end
	end
endmodule // fpd_pwm_top
`default_nettype wire

// *** fpd_defs.vh ***
// register map, field positions, reset values and timing constants of the fine pwm timer
`ifndef FPD_DEFS_VH
`define FPD_DEFS_VH

// byte addresses inside the shared window: bit 1 picks the pair, bit 0 the byte
`define FPD_ADDR_PAIR0_HI 2'h0
`define FPD_ADDR_PAIR0_LO 2'h1
`define FPD_ADDR_PAIR1_HI 2'h2
`define FPD_ADDR_PAIR1_LO 2'h3

// modulator_control_reg fields
`define FPD_CTL_RSV7 7
`define FPD_CTL_RUN 6
`define FPD_CTL_EN_B 3
`define FPD_CTL_EN_A 2
`define FPD_CTL_POL 1
`define FPD_CTL_CLKSEL 0
`define FPD_CTL_RO_ONES 8'h30
`define FPD_CTL_RST 8'h00

// duty value word fields
`define FPD_DUTY_MSB 15
`define FPD_DUTY_LSB 2
`define FPD_DUTY_CARRIER 1
`define FPD_DUTY_RSV 0

// counter low byte fields
`define FPD_CNTL_RSV 1
`define FPD_CNTL_BANK 0

// reset values, counter hold value and unmapped read value
`define FPD_DUTY_RST 14'h3fff
`define FPD_CARRIER_RST 1'b1
`define FPD_BANK_RST 1'b1
`define FPD_CNT_RST 14'h0000
`define FPD_CNT_HOLD 14'h0003
`define FPD_TEMP_RST 8'h00
`define FPD_UNMAPPED 8'hff

// valid duty ranges per carrier setting
`define FPD_MIN_CARRIER0 14'h0100
`define FPD_MIN_CARRIER1 14'h0040

// resolution periods in system clocks, minus one
`define FPD_DIV_1 14'h0000
`define FPD_DIV_2 14'h0001
`define FPD_DIV_64 14'h003f
`define FPD_DIV_128 14'h007f
`define FPD_DIV_256 14'h00ff
`define FPD_DIV_1024 14'h03ff
`define FPD_DIV_4096 14'h0fff
`define FPD_DIV_16384 14'h3fff

`endif

// *** fpd_chan.v ***
// one modulator channel: compares the shared counter with its duty value
`timescale 1ns/1ps
`default_nettype none
`include "fpd_defs.vh"
module fpd_chan #(
	parameter CNT_W = 14
) (
	input wire sys_clk,
	input wire srst,
	input wire [CNT_W-1:0] cnt,
	input wire [CNT_W-1:0] duty,
	input wire carrier_sel,
	output reg wave_reg
);
	reg [5:0] cyc6;
	reg [7:0] cyc8;
	reg [5:0] rev6;
	reg [7:0] rev8;
	reg add;
	reg in_range;
	reg [8:0] limit;
	reg [8:0] pos;
	reg wave_next;
	integer i;

	always @* begin
		cyc6 = cnt[13:8];
		cyc8 = cnt[13:6];
		// 12-bit use: top counter bits take no part
		if (duty[1:0] == 2'b00) begin
			cyc6[5:4] = 2'b00;
			cyc8[7:6] = 2'b00;
		end
		for (i = 0; i < 6; i = i + 1) begin
			rev6[i] = cyc6[5-i];
		end
		for (i = 0; i < 8; i = i + 1) begin
			rev8[i] = cyc8[7-i];
		end
		if (carrier_sel) begin
			// base cycle of 256 periods, 64 base cycles per frame
			pos = {1'b0, cnt[7:0]};
			add = (rev6 < duty[5:0]);
			limit = {1'b0, duty[13:6]} + {8'h00, add};
			in_range = (duty >= `FPD_MIN_CARRIER1);
		end else begin
			// base cycle of 64 periods, 256 base cycles per frame
			pos = {3'b000, cnt[5:0]};
			add = (rev8 < duty[7:0]);
			limit = {3'b000, duty[13:8]} + {8'h00, add};
			in_range = (duty >= `FPD_MIN_CARRIER0);
		end
		wave_next = in_range & (pos < limit);
	end

	always @(posedge sys_clk) begin
		if (srst) begin
			wave_reg <= 1'b0;
		end else begin
			wave_reg <= wave_next;
		end
	end
endmodule // fpd_chan
`default_nettype wire

// *** fpd_pwm_chk_sva.sv ***
// port checker for the fine pwm timer
`timescale 1ns/1ps
`default_nettype none
module fpd_pwm_chk (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic cpu_sel,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [1:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic shared_space_select_bit,
	input wire logic [7:0] cpu_rdata,
	input wire logic channel_a_output_pin,
	input wire logic channel_b_output_pin
);
	logic [7:0] ctl_reg;
	logic bank_reg;
	wire logic rd = cpu_sel && cpu_rd && !cpu_wr && shared_space_select_bit;
	wire logic wr = cpu_sel && cpu_wr && shared_space_select_bit;
	always @(posedge sys_clk) begin
		if (srst) begin
			ctl_reg <= 8'h00;
			bank_reg <= 1'b1;
		end else begin
			if (wr && cpu_addr == 2'h0 && bank_reg)
				ctl_reg <= cpu_wdata;
			if (wr && cpu_addr == 2'h3)
				bank_reg <= cpu_wdata[0];
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence run_held;
		(ctl_reg[6] && !(wr && cpu_addr == 2'h3))[*3];
	endsequence
	reset_outs_a: assert property ($fell(srst) |-> cpu_rdata == 8'h00 &&
		!channel_a_output_pin && !channel_b_output_pin) else $error("bad reset outputs");
	rdata_hold_a: assert property (!rd |=> $stable(cpu_rdata))
		else $error("rdata moved");
	bank_read_a: assert property (rd && cpu_addr == 2'h3 |=>
		cpu_rdata[0] == bank_reg && (!bank_reg || cpu_rdata[1])) else $error("bad bank bit");
	ctl_read_a: assert property (rd && cpu_addr == 2'h0 && bank_reg |=>
		cpu_rdata == (ctl_reg | 8'h30)) else $error("bad control read");
	low_read_a: assert property (rd && cpu_addr == 2'h1 |=>
		cpu_rdata[0] && (!bank_reg || cpu_rdata == 8'hff)) else $error("bad low read");
	pin_a_off_a: assert property ((!ctl_reg[2])[*3] |-> !channel_a_output_pin)
		else $error("pin a driven");
	pin_b_off_a: assert property ((!ctl_reg[3])[*3] |-> !channel_b_output_pin)
		else $error("pin b driven");
	run_hold_a: assert property (run_held ##0 (rd && cpu_addr == 2'h2 && bank_reg) |=>
		cpu_rdata == 8'h03) else $error("counter not held");
endmodule // fpd_pwm_chk
bind fpd_pwm_top fpd_pwm_chk u_chk (.sys_clk, .srst, .cpu_sel, .cpu_rd, .cpu_wr, .cpu_addr,
	.cpu_wdata, .shared_space_select_bit, .cpu_rdata, .channel_a_output_pin,
	.channel_b_output_pin);
`default_nettype wire

// *** fpd_lpf.sv ***
// low-pass filter model: integrates the time a pin is high
`timescale 1ns/1ps
`default_nettype none
module fpd_lpf (
	input wire logic sys_clk,
	input wire logic clr,
	input wire logic pin,
	output var logic [15:0] acc_reg
);
	always @(posedge sys_clk) begin
		if (clr)
			acc_reg <= 16'h0000;
		else
			acc_reg <= acc_reg + {15'h0000, pin};
	end
endmodule // fpd_lpf
`default_nettype wire

// *** testbench.sv ***
// self-checking testbench for the fine pwm timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk, srst, cpu_sel, cpu_rd, cpu_wr, shared_space_select_bit, clr;
	logic [1:0] cpu_addr, res_ext_sel;
	logic [7:0] cpu_wdata;
	wire [7:0] cpu_rdata;
	wire channel_a_output_pin, channel_b_output_pin;
	wire [15:0] acc_a, acc_b;
	int errors, samples_checked;
	int div[8] = '{1, 2, 64, 128, 256, 1024, 4096, 16384};
	fpd_pwm_top DUT (.sys_clk, .srst, .cpu_sel, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_wdata,
		.shared_space_select_bit, .res_ext_sel, .cpu_rdata, .channel_a_output_pin,
		.channel_b_output_pin);
	fpd_lpf u_lpf_a (.sys_clk, .clr, .pin(channel_a_output_pin), .acc_reg(acc_a));
	fpd_lpf u_lpf_b (.sys_clk, .clr, .pin(channel_b_output_pin), .acc_reg(acc_b));
	initial begin
		sys_clk = 0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task chk(input logic [15:0] s, input logic [15:0] e, input string n);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task cyc();
		@(posedge sys_clk);
		#1;
	endtask
	// one register access; a read compares with d
	task xf(input logic w, input logic [1:0] a, input logic [7:0] d);
		cpu_sel = 1;
		cpu_wr = w;
		cpu_rd = !w;
		cpu_addr = a;
		cpu_wdata = d;
		cyc();
		cpu_sel = 0;
		cyc();
		if (!w)
			chk({8'h00, cpu_rdata}, {8'h00, d}, "cpu_rdata");
	endtask
	task meas(input int n, input logic [15:0] ea, input logic [15:0] eb);
		repeat (4) cyc();
		clr = 1;
		cyc();
		clr = 0;
		repeat (n) cyc();
		chk(acc_a, ea, "acc_a");
		chk(acc_b, eb, "acc_b");
	endtask
	task results();
		if (errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		errors = 0;
		samples_checked = 0;
		srst = 1;
		cpu_sel = 0;
		cpu_rd = 0;
		cpu_wr = 0;
		cpu_addr = 2'h0;
		cpu_wdata = 8'h00;
		shared_space_select_bit = 1;
		res_ext_sel = 2'h0;
		clr = 0;
		repeat (20) cyc();
		srst = 0;
		xf(0, 2'h0, 8'h30);
		xf(0, 2'h1, 8'hff);
		xf(1, 2'h0, 8'h4c);
		repeat (4) cyc();
		xf(0, 2'h2, 8'h03);
		xf(0, 2'h3, 8'h03);
		shared_space_select_bit = 0;
		xf(1, 2'h0, 8'h00);
		shared_space_select_bit = 1;
		xf(0, 2'h0, 8'h7c);
		for (int i = 2; i < 8; i++) begin
			res_ext_sel = i[2:1];
			xf(1, 2'h0, {7'h06, i[0]});
			xf(1, 2'h2, 8'h00);
			xf(1, 2'h3, 8'h03);
			repeat (div[i] * 3 / 2) cyc();
			xf(0, 2'h2, 8'h01);
		end
		xf(1, 2'h2, 8'hbc);
		xf(1, 2'h3, 8'h53);
		xf(0, 2'h2, 8'hbc);
		xf(0, 2'h3, 8'h53);
		res_ext_sel = 2'h0;
		xf(1, 2'h0, 8'h0c);
		xf(1, 2'h2, 8'hff);
		xf(1, 2'h3, 8'h01);
		xf(0, 2'h2, 8'h00);
		xf(0, 2'h3, 8'h83);
		xf(1, 2'h3, 8'h00);
		xf(1, 2'h0, 8'h80);
		xf(1, 2'h1, 8'h02);
		xf(1, 2'h2, 8'h40);
		xf(1, 2'h3, 8'h02);
		xf(0, 2'h0, 8'h80);
		xf(0, 2'h1, 8'h03);
		xf(0, 2'h2, 8'h40);
		xf(0, 2'h3, 8'h02);
		meas(1024, 16'd512, 16'd256);
		xf(1, 2'h0, 8'h80);
		xf(1, 2'h1, 8'h06);
		meas(16384, 16'd8193, 16'd4096);
		xf(1, 2'h0, 8'h00);
		xf(1, 2'h1, 8'h82);
		xf(1, 2'h2, 8'h40);
		xf(1, 2'h3, 8'h01);
		xf(1, 2'h0, 8'h0e);
		meas(1024, 16'd1024, 16'd768);
		xf(1, 2'h0, 8'h06);
		meas(1024, 16'd1024, 16'd0);
		results();
	end
endmodule // testbench
`default_nettype wire
